// File: eba_pkg.sv
package eba_pkg;

  // ------------------------------------------------------------
  // Register map and bus constants
  // ------------------------------------------------------------
  localparam int              ADDR_W      = 9;
  localparam int              NUM_REGS    = 32;
  localparam logic [8:0]      CMD_OFS     = 9'h000;
  localparam logic [8:0]      STAT_OFS    = 9'h004;
  localparam logic [8:0]      REGS_OFS    = 9'h100;
  localparam logic [8:0]      REGS_SPAN   = 9'h080;
  localparam int              BUSY_BIT    = 8;
  localparam int              IMM_WORD_W  = 6;
  localparam logic [3:0]      STRB_ALL    = 4'hf;
  localparam logic [1:0]      RESP_OKAY   = 2'b00;
  localparam logic [1:0]      RESP_SLVERR = 2'b10;

  // ------------------------------------------------------------
  // Datapath constants
  // ------------------------------------------------------------
  localparam logic [7:0]      BYTE_ONES     = 8'hff;
  localparam logic [7:0]      BYTE_SIGN_MIN = 8'h80;
  localparam logic [7:0]      BYTE_SIGN_MAX = 8'h7f;

  typedef enum logic [4:0] {
    op_add_regs        = 5'h00,
    op_add_carry       = 5'h01,
    op_add_imm_word    = 5'h02,
    op_sub_regs        = 5'h03,
    op_sub_imm         = 5'h04,
    op_sub_regs_borrow = 5'h05,
    op_sub_imm_borrow  = 5'h06,
    op_sub_imm_word    = 5'h07,
    op_and_regs        = 5'h08,
    op_and_imm         = 5'h09,
    op_or_regs         = 5'h0a,
    op_or_imm          = 5'h0b,
    op_xor_regs        = 5'h0c,
    op_ones_complement = 5'h0d,
    op_twos_negate     = 5'h0e,
    op_set_mask_bits   = 5'h0f,
    op_clear_mask_bits = 5'h10,
    op_increment_reg   = 5'h11,
    op_decrement_reg   = 5'h12,
    op_test_reg        = 5'h13,
    op_zero_reg        = 5'h14,
    op_ones_reg        = 5'h15
  } eba_op_t;

  typedef enum logic [1:0] {
    st_idle    = 2'b00,
    st_exec    = 2'b01,
    st_word_hi = 2'b11
  } eba_state_t;

  typedef struct packed {
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } eba_flags_t;

  typedef struct packed {
    logic [7:0] imm;
    logic [2:0] rsv2;
    logic [4:0] src;
    logic [2:0] rsv1;
    logic [4:0] dst;
    logic [2:0] rsv0;
    eba_op_t    op;
  } eba_cmd_t;

  localparam eba_flags_t FLAGS_RST = 6'h00;
  localparam eba_cmd_t   CMD_RST   = 32'h0000_0000;

  function automatic logic op_is_known(input logic [4:0] code);
    return code <= op_ones_reg;
  endfunction : op_is_known

  function automatic logic op_is_word(input eba_op_t op);
    return (op == op_add_imm_word) || (op == op_sub_imm_word);
  endfunction : op_is_word

  function automatic logic op_uses_imm(input eba_op_t op);
    return op inside {op_add_imm_word, op_sub_imm, op_sub_imm_borrow, op_sub_imm_word,
                      op_and_imm, op_or_imm, op_set_mask_bits, op_clear_mask_bits};
  endfunction : op_uses_imm

endpackage : eba_pkg

// File: eba_regfile.sv
module eba_regfile #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 8
) (
  input  wire logic                     aclk,     // Core clock
  input  wire logic                     aresetn,  // Sync reset, active low
  input  wire logic                     we,       // Write enable
  input  wire logic [$clog2(DEPTH)-1:0] waddr,    // Write index
  input  wire logic [WIDTH-1:0]         wdata,    // Write value
  input  wire logic [$clog2(DEPTH)-1:0] raddr_a,  // Read index, port a
  output logic      [WIDTH-1:0]         rdata_a,  // Read value, port a
  input  wire logic [$clog2(DEPTH)-1:0] raddr_b,  // Read index, port b
  output logic      [WIDTH-1:0]         rdata_b,  // Read value, port b
  input  wire logic [$clog2(DEPTH)-1:0] raddr_c,  // Read index, port c
  output logic      [WIDTH-1:0]         rdata_c   // Read value, port c
);

  // Word pairs need an even, power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("eba_regfile: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  assign rdata_a = mem_r[raddr_a];
  assign rdata_b = mem_r[raddr_b];
  assign rdata_c = mem_r[raddr_c];

endmodule : eba_regfile

// File: eba_alu_core.sv
module eba_alu_core (
  input  wire eba_pkg::eba_op_t    op,        // Operation
  input  wire logic [7:0]          opa,       // Destination operand
  input  wire logic [7:0]          opb,       // Source register or immediate
  input  wire eba_pkg::eba_flags_t flags_in,  // Current flags
  output logic [7:0]               res,       // Result byte
  output eba_pkg::eba_flags_t      flags_out  // Next flags
);

  logic [8:0] sum;
  logic [7:0] x;
  logic [7:0] y;
  logic       bin;

  always_comb begin
    res       = opa;
    flags_out = flags_in;
    sum       = '0;
    x         = opa;
    y         = opb;
    bin       = 1'b0;
    case (op)
      eba_pkg::op_add_regs, eba_pkg::op_add_carry: begin
        bin = (op == eba_pkg::op_add_carry) & flags_in.c;
        sum = {1'b0, opa} + {1'b0, opb} + {8'h00, bin};
        res = sum[7:0];
        flags_out.c = sum[8];
        flags_out.h = (opa[3] & opb[3]) | (opb[3] & ~res[3]) | (~res[3] & opa[3]);
        flags_out.v = (opa[7] & opb[7] & ~res[7]) | (~opa[7] & ~opb[7] & res[7]);
        flags_out.n = res[7];
        flags_out.z = (res == 8'h00);
      end
      eba_pkg::op_sub_regs, eba_pkg::op_sub_imm, eba_pkg::op_sub_regs_borrow,
      eba_pkg::op_sub_imm_borrow, eba_pkg::op_twos_negate: begin
        // Negate runs the subtractor as zero minus the operand
        x   = (op == eba_pkg::op_twos_negate) ? 8'h00 : opa;
        y   = (op == eba_pkg::op_twos_negate) ? opa : opb;
        bin = (op inside {eba_pkg::op_sub_regs_borrow, eba_pkg::op_sub_imm_borrow})
              & flags_in.c;
        sum = {1'b0, x} - {1'b0, y} - {8'h00, bin};
        res = sum[7:0];
        flags_out.c = sum[8];
        flags_out.h = (~x[3] & y[3]) | (y[3] & res[3]) | (res[3] & ~x[3]);
        flags_out.v = (x[7] & ~y[7] & ~res[7]) | (~x[7] & y[7] & res[7]);
        flags_out.n = res[7];
        // Borrow chains keep zero only if every byte so far was zero
        flags_out.z = (res == 8'h00)
                      & ((op inside {eba_pkg::op_sub_regs_borrow,
                                     eba_pkg::op_sub_imm_borrow}) ? flags_in.z : 1'b1);
      end
      eba_pkg::op_and_regs, eba_pkg::op_and_imm, eba_pkg::op_test_reg,
      eba_pkg::op_or_regs, eba_pkg::op_or_imm, eba_pkg::op_set_mask_bits,
      eba_pkg::op_xor_regs, eba_pkg::op_zero_reg, eba_pkg::op_clear_mask_bits: begin
        case (op)
          eba_pkg::op_and_regs, eba_pkg::op_and_imm: res = opa & opb;
          eba_pkg::op_test_reg:                      res = opa & opa;
          eba_pkg::op_xor_regs:                      res = opa ^ opb;
          eba_pkg::op_zero_reg:                      res = opa ^ opa;
          eba_pkg::op_clear_mask_bits:               res = opa & (eba_pkg::BYTE_ONES - opb);
          default:                                   res = opa | opb;
        endcase
        flags_out.v = 1'b0;
        flags_out.n = res[7];
        flags_out.z = (res == 8'h00);
      end
      eba_pkg::op_ones_complement: begin
        res = eba_pkg::BYTE_ONES - opa;
        flags_out.c = 1'b1;
        flags_out.v = 1'b0;
        flags_out.n = res[7];
        flags_out.z = (res == 8'h00);
      end
      eba_pkg::op_increment_reg, eba_pkg::op_decrement_reg: begin
        res = (op == eba_pkg::op_increment_reg) ? opa + 8'h01 : opa - 8'h01;
        flags_out.v = (op == eba_pkg::op_increment_reg) ? (res == eba_pkg::BYTE_SIGN_MIN)
                                                        : (res == eba_pkg::BYTE_SIGN_MAX);
        flags_out.n = res[7];
        flags_out.z = (res == 8'h00);
      end
      eba_pkg::op_ones_reg: res = eba_pkg::BYTE_ONES;
      default:              res = opa;
    endcase
  end

endmodule : eba_alu_core

// File: eba_alu_top.sv
// What this block does
// - Add two registers, with optional carry in, flags Z C N V H, one clock
// - Add immediate to register pair, flags Z C N V S, two clocks
// - Subtract register or immediate from destination, flags Z C N V H, one clock
// - Subtract register and carry from destination, flags Z C N V H, one clock
// - Subtract immediate and carry from destination, flags Z C N V H, one clock
// - Subtract immediate from register pair, flags Z C N V S, two clocks
// - AND with register or immediate, flags Z N V only, one clock
// - OR with register or immediate, flags Z N V only, one clock
// - Exclusive OR of two registers, flags Z N V, one clock
// - Set bits: OR immediate mask into destination, flags Z N V, one clock
// - Clear bits: AND with all ones minus mask, flags Z N V, one clock
// - Test: AND register with itself, register kept, flags Z N V, one clock
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
module eba_alu_top (
  input  wire logic        aclk,           // Core clock
  input  wire logic        aresetn,        // Sync reset, active low
  input  wire logic [8:0]  s_axi_awaddr,   // Write address
  input  wire logic        s_axi_awvalid,  // Write address valid
  output logic             s_axi_awready,  // Write address ready
  input  wire logic [31:0] s_axi_wdata,    // Write data
  input  wire logic [3:0]  s_axi_wstrb,    // Write strobes
  input  wire logic        s_axi_wvalid,   // Write data valid
  output logic             s_axi_wready,   // Write data ready
  output logic [1:0]       s_axi_bresp,    // Write response
  output logic             s_axi_bvalid,   // Write response valid
  input  wire logic        s_axi_bready,   // Write response ready
  input  wire logic [8:0]  s_axi_araddr,   // Read address
  input  wire logic        s_axi_arvalid,  // Read address valid
  output logic             s_axi_arready,  // Read address ready
  output logic [31:0]      s_axi_rdata,    // Read data
  output logic [1:0]       s_axi_rresp,    // Read response
  output logic             s_axi_rvalid,   // Read data valid
  input  wire logic        s_axi_rready    // Read data ready
);

  typedef struct packed {
    eba_pkg::eba_state_t state;
    eba_pkg::eba_flags_t flags;
    eba_pkg::eba_cmd_t   cmd;
    eba_pkg::eba_flags_t word_flags;
    logic [7:0]          word_hi;
    logic                aw_got;
    logic [8:0]          aw_addr;
    logic                w_got;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } eba_top_state_t;

  eba_top_state_t      s_r;
  eba_top_state_t      s_nxt;
  logic                busy;
  logic                is_word;
  logic [4:0]          pair_lo;
  logic [4:0]          raddr_a;
  logic [4:0]          raddr_b;
  logic [7:0]          rdata_a;
  logic [7:0]          rdata_b;
  logic [7:0]          rdata_c;
  logic [7:0]          opb;
  logic [7:0]          core_res;
  eba_pkg::eba_flags_t core_flags;
  logic [16:0]         word_sum;
  logic [15:0]         word_imm;
  logic                rf_we;
  logic [4:0]          rf_waddr;
  logic [7:0]          rf_wdata;

  function automatic logic in_regs(input logic [8:0] a);
    return (a >= eba_pkg::REGS_OFS) && (a < eba_pkg::REGS_OFS + eba_pkg::REGS_SPAN);
  endfunction : in_regs

  // ------------------------------------------------------------
  // Operand selection and datapath
  // ------------------------------------------------------------
  assign busy     = (s_r.state != eba_pkg::st_idle);
  assign is_word  = eba_pkg::op_is_word(s_r.cmd.op);
  assign pair_lo  = {s_r.cmd.dst[4:1], 1'b0};
  assign raddr_a  = is_word ? pair_lo : s_r.cmd.dst;
  assign raddr_b  = is_word ? {s_r.cmd.dst[4:1], 1'b1} : s_r.cmd.src;
  assign opb      = eba_pkg::op_uses_imm(s_r.cmd.op) ? s_r.cmd.imm : rdata_b;
  assign word_imm = {10'h000, s_r.cmd.imm[eba_pkg::IMM_WORD_W-1:0]};
  // Pair arithmetic is done whole in the first cycle, high byte lands in the second
  assign word_sum = (s_r.cmd.op == eba_pkg::op_sub_imm_word)
                  ? {1'b0, rdata_b, rdata_a} - {1'b0, word_imm}
                  : {1'b0, rdata_b, rdata_a} + {1'b0, word_imm};

  eba_regfile #(
    .DEPTH (eba_pkg::NUM_REGS),
    .WIDTH (8)
  ) u_regfile (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (rf_we),
    .waddr   (rf_waddr),
    .wdata   (rf_wdata),
    .raddr_a (raddr_a),
    .rdata_a (rdata_a),
    .raddr_b (raddr_b),
    .rdata_b (rdata_b),
    .raddr_c (s_axi_araddr[6:2]),
    .rdata_c (rdata_c)
  );

  eba_alu_core u_core (
    .op        (s_r.cmd.op),
    .opa       (rdata_a),
    .opb       (opb),
    .flags_in  (s_r.flags),
    .res       (core_res),
    .flags_out (core_flags)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt    = s_r;
    rf_we    = 1'b0;
    rf_waddr = '0;
    rf_wdata = '0;

    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_got  = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_got  = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end

    // Writes are refused while busy so the register port never sees two writers
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = eba_pkg::RESP_OKAY;
      if (s_r.aw_addr[8:2] == eba_pkg::CMD_OFS[8:2]) begin
        if (busy || s_r.w_strb != eba_pkg::STRB_ALL
            || !eba_pkg::op_is_known(s_r.w_data[4:0])) begin
          s_nxt.bresp = eba_pkg::RESP_SLVERR;
        end else begin
          s_nxt.cmd      = eba_pkg::eba_cmd_t'(s_r.w_data);
          s_nxt.cmd.rsv0 = '0;
          s_nxt.cmd.rsv1 = '0;
          s_nxt.cmd.rsv2 = '0;
          s_nxt.state    = eba_pkg::st_exec;
        end
      end else if (s_r.aw_addr[8:2] == eba_pkg::STAT_OFS[8:2]) begin
        if (busy) begin
          s_nxt.bresp = eba_pkg::RESP_SLVERR;
        end else if (s_r.w_strb[0]) begin
          s_nxt.flags = eba_pkg::eba_flags_t'(s_r.w_data[5:0]);
        end
      end else if (in_regs(s_r.aw_addr)) begin
        if (busy) begin
          s_nxt.bresp = eba_pkg::RESP_SLVERR;
        end else if (s_r.w_strb[0]) begin
          rf_we    = 1'b1;
          rf_waddr = s_r.aw_addr[6:2];
          rf_wdata = s_r.w_data[7:0];
        end
      end else begin
        s_nxt.bresp = eba_pkg::RESP_SLVERR;
      end
    end else if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;

    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = eba_pkg::RESP_OKAY;
      s_nxt.rdata  = '0;
      if (s_axi_araddr[8:2] == eba_pkg::CMD_OFS[8:2]) begin
        s_nxt.rdata = s_r.cmd;
      end else if (s_axi_araddr[8:2] == eba_pkg::STAT_OFS[8:2]) begin
        s_nxt.rdata[5:0]               = s_r.flags;
        s_nxt.rdata[eba_pkg::BUSY_BIT] = busy;
      end else if (in_regs(s_axi_araddr)) begin
        s_nxt.rdata[7:0] = rdata_c;
      end else begin
        s_nxt.rresp = eba_pkg::RESP_SLVERR;
      end
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    s_nxt.arready = !s_nxt.rvalid;

    case (s_r.state)
      eba_pkg::st_exec: begin
        if (is_word) begin
          rf_we                  = 1'b1;
          rf_waddr               = pair_lo;
          rf_wdata               = word_sum[7:0];
          s_nxt.word_hi          = word_sum[15:8];
          s_nxt.word_flags       = s_r.flags;
          s_nxt.word_flags.c     = word_sum[16];
          s_nxt.word_flags.n     = word_sum[15];
          s_nxt.word_flags.z     = (word_sum[15:0] == 16'h0000);
          s_nxt.word_flags.v     = (s_r.cmd.op == eba_pkg::op_sub_imm_word)
                                 ? (rdata_b[7] & ~word_sum[15])
                                 : (~rdata_b[7] & word_sum[15]);
          s_nxt.word_flags.s     = word_sum[15] ^ s_nxt.word_flags.v;
          s_nxt.state            = eba_pkg::st_word_hi;
        end else begin
          // Test only sets flags; the register keeps its value
          if (s_r.cmd.op != eba_pkg::op_test_reg) begin
            rf_we    = 1'b1;
            rf_waddr = s_r.cmd.dst;
            rf_wdata = core_res;
          end
          s_nxt.flags = core_flags;
          s_nxt.state = eba_pkg::st_idle;
        end
      end
      eba_pkg::st_word_hi: begin
        rf_we       = 1'b1;
        rf_waddr    = {s_r.cmd.dst[4:1], 1'b1};
        rf_wdata    = s_r.word_hi;
        s_nxt.flags = s_r.word_flags;
        s_nxt.state = eba_pkg::st_idle;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r       <= '0;
      s_r.flags <= eba_pkg::FLAGS_RST;
      s_r.cmd   <= eba_pkg::CMD_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready  = s_r.wready;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic       exec;
  logic [7:0] add_ref;
  logic [15:0] word_ref;
  assign exec    = (s_r.state == eba_pkg::st_exec);
  assign word_ref = {rdata_b, rdata_a} + ((s_r.cmd.op == eba_pkg::op_sub_imm_word)
                                          ? (16'h0000 - word_imm) : word_imm);
  assign add_ref = rdata_a + opb + {7'h00, (s_r.cmd.op == eba_pkg::op_add_carry) & s_r.flags.c};

  sequence s_word_lo;
    exec && is_word;
  endsequence
  sequence s_word_rest;
    (s_r.state == eba_pkg::st_word_hi) && rf_we ##1 (s_r.state == eba_pkg::st_idle);
  endsequence

  property p_add;
    exec && (s_r.cmd.op inside {eba_pkg::op_add_regs, eba_pkg::op_add_carry})
      |-> rf_we && rf_waddr == s_r.cmd.dst && rf_wdata == add_ref ##1 !busy;
  endproperty
  a_add: assert property (p_add) else $error("add result or timing wrong");

  property p_word;
    s_word_lo |=> s_word_rest;
  endproperty
  a_word: assert property (p_word) else $error("word op not two clocks");

  property p_word_sign;
    s_word_lo |-> rf_wdata == word_ref[7:0] ##1 rf_wdata == $past(word_ref[15:8])
      ##1 s_r.flags.s == (s_r.flags.n ^ s_r.flags.v);
  endproperty
  a_word_sign: assert property (p_word_sign) else $error("word sign flag wrong");

  property p_sub_borrow;
    exec && (s_r.cmd.op inside {eba_pkg::op_sub_regs, eba_pkg::op_sub_imm})
      |=> s_r.flags.c == ($past(opb) > $past(rdata_a));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("subtract carry wrong");

  property p_sbc;
    exec && (s_r.cmd.op inside {eba_pkg::op_sub_regs_borrow, eba_pkg::op_sub_imm_borrow})
      |-> rf_wdata == 8'(rdata_a - opb - {7'h00, s_r.flags.c});
  endproperty
  a_sbc: assert property (p_sbc) else $error("borrow subtract result wrong");

  property p_logic_v;
    exec && (s_r.cmd.op inside {eba_pkg::op_and_regs, eba_pkg::op_and_imm,
                               eba_pkg::op_or_regs, eba_pkg::op_or_imm, eba_pkg::op_xor_regs})
      |=> !s_r.flags.v && s_r.flags.z == ($past(rf_wdata) == 8'h00);
  endproperty
  a_logic_v: assert property (p_logic_v) else $error("logic op flags wrong");

  property p_mask;
    exec && (s_r.cmd.op == eba_pkg::op_clear_mask_bits) |-> rf_wdata == (rdata_a & ~opb);
  endproperty
  a_mask: assert property (p_mask) else $error("clear bits result wrong");

  property p_test;
    exec && (s_r.cmd.op == eba_pkg::op_test_reg)
      |-> !rf_we ##1 s_r.flags.n == $past(rdata_a[7]);
  endproperty
  a_test: assert property (p_test) else $error("test changed register");

  property p_incdec;
    exec && (s_r.cmd.op inside {eba_pkg::op_increment_reg, eba_pkg::op_decrement_reg})
      |=> s_r.flags.c == $past(s_r.flags.c);
  endproperty
  a_incdec: assert property (p_incdec) else $error("inc or dec touched carry");

  property p_ones;
    exec && (s_r.cmd.op == eba_pkg::op_ones_reg)
      |-> rf_wdata == eba_pkg::BYTE_ONES ##1 s_r.flags == $past(s_r.flags);
  endproperty
  a_ones: assert property (p_ones) else $error("set all ones wrong");

endmodule : eba_alu_top

// File: eba_axi_mst.sv
// ----------------------------------------
// Register bus master model
// ----------------------------------------
module eba_axi_mst (
  input  wire logic        aclk,           // Clock
  output logic      [8:0]  s_axi_awaddr,   // AW
  output logic             s_axi_awvalid,  // AW
  input  wire logic        s_axi_awready,  // AW
  output logic      [31:0] s_axi_wdata,    // W
  output logic      [3:0]  s_axi_wstrb,    // W
  output logic             s_axi_wvalid,   // W
  input  wire logic        s_axi_wready,   // W
  input  wire logic [1:0]  s_axi_bresp,    // B
  input  wire logic        s_axi_bvalid,   // B
  output logic             s_axi_bready,   // B
  output logic      [8:0]  s_axi_araddr,   // AR
  output logic             s_axi_arvalid,  // AR
  input  wire logic        s_axi_arready,  // AR
  input  wire logic [31:0] s_axi_rdata,    // R
  input  wire logic [1:0]  s_axi_rresp,    // R
  input  wire logic        s_axi_rvalid,   // R
  output logic             s_axi_rready    // R
);
  timeunit 1ns / 1ns;
  initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
           s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
  // Both channels offered together; each dropped once taken
  task automatic wr(input logic [8:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [8:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : eba_axi_mst

// File: testbench.sv
module testbench;
  timeunit 1ns / 1ns;
  logic aclk, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [8:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic aresetn = 1'b0;
  int n_errors = 0;
  int tests_run = 0;
  eba_alu_top u_eba_alu_top (.*);
  eba_axi_mst m (.*);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Pair 24/25: low byte a, high byte b; b doubles as immediate
  task automatic t(input logic [55:0] v);
    logic [7:0] op, a, b, f, er, eh, ef;
    {op, a, b, f, er, eh, ef} = v;
    m.wr(eba_pkg::REGS_OFS + 9'h060, {24'h0, a}, r);
    m.wr(eba_pkg::REGS_OFS + 9'h064, {24'h0, b}, r);
    m.wr(eba_pkg::STAT_OFS, {24'h0, f}, r);
    m.wr(eba_pkg::CMD_OFS, {b, 8'h19, 8'h18, op}, r);
    chk({30'h0, r}, {30'h0, eba_pkg::RESP_OKAY});
    d = 32'h0000_0100;
    repeat (8) if (d[eba_pkg::BUSY_BIT] !== 1'b0) m.rd(eba_pkg::STAT_OFS, d, r);
    chk(d, {24'h0, ef});
    m.rd(eba_pkg::REGS_OFS + 9'h060, d, r);
    chk(d, {24'h0, er});
    m.rd(eba_pkg::REGS_OFS + 9'h064, d, r);
    chk(d, {24'h0, eh});
    $display("op %h done", op);
  endtask : t
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    m.rd(eba_pkg::STAT_OFS, d, r);
    chk(d, 32'h0);
    m.rd(9'h008, d, r);
    chk({d[29:0], r}, {30'h0, eba_pkg::RESP_SLVERR});
    t(56'h00_0f_01_00_10_01_20);
    t(56'h01_ff_00_01_00_00_23);
    t(56'h02_ff_7f_00_3e_80_0c);
    t(56'h03_00_01_00_ff_01_25);
    t(56'h04_10_01_00_0f_01_20);
    t(56'h05_01_00_03_00_00_02);
    t(56'h06_80_00_01_7f_00_28);
    t(56'h07_00_81_00_ff_80_14);
    t(56'h08_ff_80_00_80_80_04);
    t(56'h09_f0_0f_09_00_0f_03);
    t(56'h0a_80_01_00_81_01_04);
    t(56'h0b_00_00_00_00_00_02);
    t(56'h0c_55_55_20_00_55_22);
    t(56'h0f_01_80_00_81_80_04);
    t(56'h10_ff_0f_00_f0_0f_04);
    t(56'h13_80_00_08_80_00_04);
    t(56'h0d_00_00_00_ff_00_05);
    t(56'h0e_01_00_00_ff_00_25);
    t(56'h11_7f_00_01_80_00_0d);
    t(56'h12_80_00_00_7f_00_08);
    t(56'h14_5a_00_01_00_00_03);
    t(56'h15_00_00_15_ff_00_15);
    m.wr(eba_pkg::CMD_OFS, 32'h0000_0016, r);
    chk({30'h0, r}, {30'h0, eba_pkg::RESP_SLVERR});
    m.wr(9'h008, 32'h0000_0001, r);
    chk({30'h0, r}, {30'h0, eba_pkg::RESP_SLVERR});
    m.rd(eba_pkg::CMD_OFS, d, r);
    chk(d, 32'h0019_1815);
    $display("refusal test done");
    conclude();
  end
  // Far beyond the roughly 600 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    conclude();
  end
endmodule : testbench
